// >>> verilog/sca_top.sv
// Stall cycle accounting: per-cycle stall categories and branch event pulses
// Behaviour
// - Each cycle lands in one of four categories
// - Four category counts sum to total cycles
// - Dependency: dispersal breaks, FP flushes, scoreboard stalls
// - Dependency excludes memory waits and clean cycles
// - Scoreboard event: dependency minus dispersal breaks
// - Memory: operand waits plus memory-access flushes
// - Memory also counts register stack engine stalls
// - Data access: memory minus register stack engine
// - Clean back-end: no stall, decoupling buffer empty or busy
// - Instruction access: clean, decoupling buffer empty, plus front-end miss
// - Flush: taken resteers and misprediction resteers
// - Misprediction flush overrides front-end bubble
// - Flush includes table, serial, bypass, exception flushes
// - Back-end flush excludes branch bubbles
// - Eight measured stall events provided
// - Path event split by direction and outcome
// - Predictor event split by stage and correctness
// - Multiway event counts multiway bundles only
// - Taken-slot event reports taken branch slot
// - Capture event per trace buffer record
`timescale 1ns/1ps
`default_nettype none
module sca_top (
    input  wire logic                   MCLK,
    input  wire logic                   RST,
    input  wire sca_pkg::sca_backend_t  BACKEND,
    input  wire sca_pkg::sca_frontend_t FRONTEND,
    input  wire sca_pkg::sca_branch_t   BRANCH,
    input  wire sca_pkg::sca_umask_t    UMASK,
    output logic                        CYCLE_EVT,
    output logic                        DEP_ALL_EVT,
    output logic                        MEMORY_EVT,
    output logic                        CLEAN_BACKEND_EVT,
    output logic                        ALL_FLUSH_EVT,
    output logic                        DEP_SCOREBOARD_EVT,
    output logic                        DATA_ACCESS_EVT,
    output logic                        INST_ACCESS_EVT,
    output logic                        BACKEND_FLUSH_EVT,
    output sca_pkg::sca_brev_t          BRANCH_EVT
);
    import sca_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Cause decode

    typedef enum logic [1:0] {
        CAT_DEPEND,
        CAT_MEMORY,
        CAT_CLEAN,
        CAT_FLUSH
    } sca_cat_t;

    logic                 be_flush_any;
    logic                 mem_flush_any;
    logic                 mem_wait_any;
    logic                 dep_any;
    logic                 disp_break;
    sca_cat_t             cat;
    logic [NUM_STALL-1:0] stall_d;
    logic [NUM_STALL-1:0] stall_q;
    logic                 cycle_q;

    // Back-end flush, memory wait and dependency sources
    always_comb begin
        be_flush_any = BACKEND.br_mispredict_flush | BACKEND.adv_load_table_flush
                     | BACKEND.serial_flush | BACKEND.bypass_flush
                     | BACKEND.ctl_spec_flush | BACKEND.exc_flush;
        mem_flush_any = BACKEND.dcache_way_flush | BACKEND.data_xlate_cache_flush;
        // spill and fill stalls join memory
        mem_wait_any = BACKEND.sb_stall_mem | mem_flush_any
                     | BACKEND.reg_stack_engine_stall;
        disp_break = BACKEND.expl_stop | BACKEND.impl_stop;
        // dependency sources, memory waits kept out
        dep_any = disp_break | BACKEND.fp_flush | BACKEND.sb_stall_nonld;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Top-level category selection

    // Priority flush, memory, dependency, clean so overlapping causes count once
    always_comb begin
        if (be_flush_any || FRONTEND.taken_resteer) begin
            cat = CAT_FLUSH;
        end else if (mem_wait_any) begin
            cat = CAT_MEMORY;
        end else if (dep_any) begin
            cat = CAT_DEPEND;
        end else begin
            cat = CAT_CLEAN;
        end
    end

    // Event vector, sub-events nested inside their category
    always_comb begin
        stall_d = '0;
        case (cat)
            CAT_FLUSH: begin
                stall_d[EV_ALL_FLUSH] = 1'b1;
                // bubbles alone stay out of back-end flush
                stall_d[EV_BE_FLUSH]  = be_flush_any;
            end
            CAT_MEMORY: begin
                stall_d[EV_MEMORY]   = 1'b1;
                stall_d[EV_DATA_ACC] = BACKEND.sb_stall_mem | mem_flush_any;
            end
            CAT_DEPEND: begin
                stall_d[EV_DEP_ALL] = 1'b1;
                stall_d[EV_DEP_SB]  = BACKEND.fp_flush | BACKEND.sb_stall_nonld;
            end
            CAT_CLEAN: begin
                // clean back-end; a busy buffer lands here too to keep the sum
                stall_d[EV_CLEAN_BE] = 1'b1;
                stall_d[EV_INST_ACC] = FRONTEND.decouple_empty
                                     & (FRONTEND.first_level_inst_cache_miss
                                     | FRONTEND.inst_xlate_buffer_miss);
            end
            default: stall_d = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers

    // cycle pulse paired with exactly one category
    always_ff @(posedge MCLK) begin
        if (RST) begin
            stall_q <= '0;
            cycle_q <= 1'b0;
        end else begin
            stall_q <= stall_d;
            cycle_q <= 1'b1;
        end
    end

    assign DEP_ALL_EVT        = stall_q[EV_DEP_ALL];
    assign MEMORY_EVT         = stall_q[EV_MEMORY];
    assign CLEAN_BACKEND_EVT  = stall_q[EV_CLEAN_BE];
    assign ALL_FLUSH_EVT      = stall_q[EV_ALL_FLUSH];
    assign DEP_SCOREBOARD_EVT = stall_q[EV_DEP_SB];
    assign DATA_ACCESS_EVT    = stall_q[EV_DATA_ACC];
    assign INST_ACCESS_EVT    = stall_q[EV_INST_ACC];
    assign BACKEND_FLUSH_EVT  = stall_q[EV_BE_FLUSH];
    assign CYCLE_EVT          = cycle_q;

    ////////////////////////////////////////////////////////////////////////////
    // Branch events

    sca_branch_class u_branch (
        .clk  (MCLK),
        .rst  (RST),
        .br   (BRANCH),
        .um   (UMASK),
        .ev_q (BRANCH_EVT)
    );

endmodule
`default_nettype wire

// >>> verilog/sca_pkg.sv
// Package for the stall cycle accounting block: carriers, encodings, field widths
package sca_pkg;

    // Widths of the branch qualification fields and of the stall vector
    localparam int STAGE_W   = 2;
    localparam int SLOT_W    = 2;
    localparam int NUM_SLOTS = 3;
    localparam int NUM_STALL = 8;

    // Predictor stage codes
    localparam logic [STAGE_W-1:0] STAGE_FIRST  = 2'h1;
    localparam logic [STAGE_W-1:0] STAGE_SECOND = 2'h2;
    localparam logic [STAGE_W-1:0] STAGE_THIRD  = 2'h3;
    localparam logic [STAGE_W-1:0] STAGE_ALL    = 2'h0;

    // Predictor outcome selector codes
    localparam logic [1:0] OUTC_ALL     = 2'h0;
    localparam logic [1:0] OUTC_CORRECT = 2'h1;
    localparam logic [1:0] OUTC_WRONG_DIR = 2'h2;
    localparam logic [1:0] OUTC_WRONG_TGT = 2'h3;

    // Taken-slot code: SLOT_NONE marks a bundle with no taken slot
    localparam logic [1:0] SLOT_NONE = 2'h3;

    // Stall vector positions
    localparam int EV_DEP_ALL   = 0;
    localparam int EV_MEMORY    = 1;
    localparam int EV_CLEAN_BE  = 2;
    localparam int EV_ALL_FLUSH = 3;
    localparam int EV_DEP_SB    = 4;
    localparam int EV_DATA_ACC  = 5;
    localparam int EV_INST_ACC  = 6;
    localparam int EV_BE_FLUSH  = 7;

    // Back-end status per cycle
    typedef struct packed {
        logic expl_stop;      // dispersal break from explicit stop
        logic impl_stop;      // dispersal break from resource or branch bundle
        logic fp_flush;       // floating-point related flush
        logic sb_stall_nonld; // scoreboard stall on non-load producer
        logic sb_stall_mem;   // waiting for load operand from memory
        logic dcache_way_flush;
        logic data_xlate_cache_flush;
        logic reg_stack_engine_stall;
        logic br_mispredict_flush;
        logic adv_load_table_flush;
        logic serial_flush;
        logic bypass_flush;
        logic ctl_spec_flush;
        logic exc_flush;
    } sca_backend_t;

    // Front-end status per cycle
    typedef struct packed {
        logic decouple_empty;
        logic first_level_inst_cache_miss;
        logic inst_xlate_buffer_miss;
        logic taken_resteer;  // bubble for a correctly predicted taken branch
    } sca_frontend_t;

    // One resolved branch bundle
    typedef struct packed {
        logic               valid;
        logic               multiway;
        logic               pred_taken;
        logic               act_taken;
        logic [STAGE_W-1:0] stage;
        logic               wrong_dir;
        logic               wrong_tgt;
        logic [SLOT_W-1:0]  taken_slot;   // SLOT_NONE when nothing taken
        logic               trace_capture;
    } sca_branch_t;

    // Unit mask for the branch events
    typedef struct packed {
        logic               path_sel_pred;   // match on predicted direction
        logic               path_pred_taken;
        logic               path_sel_act;    // match on actual outcome
        logic               path_act_taken;
        logic [STAGE_W-1:0] stage;           // STAGE_ALL matches any stage
        logic [1:0]         outcome;
        logic [SLOT_W-1:0]  slot;            // slot that the taken-slot event counts
    } sca_umask_t;

    // Branch event pulses
    typedef struct packed {
        logic path;
        logic predictor;
        logic multiway;
        logic taken_slot;
        logic capture;
    } sca_brev_t;

endpackage

// >>> verilog/sca_branch_class.sv
// Branch event classifier with unit-mask qualification
`timescale 1ns/1ps
`default_nettype none
module sca_branch_class (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire sca_pkg::sca_branch_t br,
    input  wire sca_pkg::sca_umask_t  um,
    output sca_pkg::sca_brev_t        ev_q
);
    import sca_pkg::*;

    logic      stage_hit;
    logic      outc_hit;
    logic      path_hit;
    sca_brev_t ev_d;

    // Qualifiers shared by the path, predictor and multiway events
    always_comb begin
        stage_hit = (um.stage == STAGE_ALL) || (um.stage == br.stage);
        case (um.outcome)
            OUTC_CORRECT:   outc_hit = !br.wrong_dir && !br.wrong_tgt;
            OUTC_WRONG_DIR: outc_hit = br.wrong_dir;
            OUTC_WRONG_TGT: outc_hit = br.wrong_tgt && !br.wrong_dir;
            default:        outc_hit = 1'b1;
        endcase
        path_hit = (!um.path_sel_pred || (br.pred_taken == um.path_pred_taken))
                && (!um.path_sel_act  || (br.act_taken  == um.path_act_taken));
    end

    // Event pulses, one per resolved bundle
    always_comb begin
        ev_d.path       = br.valid && path_hit && stage_hit;
        ev_d.predictor  = br.valid && stage_hit && outc_hit;
        ev_d.multiway   = br.valid && br.multiway && path_hit && outc_hit;
        ev_d.taken_slot = br.valid && br.act_taken && (br.taken_slot != SLOT_NONE)
                       && (br.taken_slot == um.slot);
        ev_d.capture    = br.valid && br.trace_capture;
    end

    // Registered pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            ev_q <= '0;
        end else begin
            ev_q <= ev_d;
        end
    end

endmodule
`default_nettype wire

// >>> testbench/sca_pipe_model.sv
// Pipeline status model: front-end and back-end causes feeding the block
`timescale 1ns/1ps
`default_nettype none
module sca_pipe_model
    import sca_pkg::*;
(
    input  wire logic [3:0]        cause,
    input  wire logic [1:0]        fe_miss,
    input  wire logic              buf_full,
    input  wire logic              resteer,
    output sca_pkg::sca_backend_t  be,
    output sca_pkg::sca_frontend_t fe
);
    // Cause code n sets one back-end flag in struct order, 0 is idle
    // one cause each
    always_comb begin
        be = '0;
        if (cause != 4'h0) be[4'he - cause] = 1'b1;
    end
    // Buffer empty unless the bench fills it, so misses reach the instruction access event
    // front-end view
    always_comb begin
        fe = '{!buf_full, fe_miss[1], fe_miss[0], resteer};
    end
endmodule
`default_nettype wire

// >>> testbench/sca_top_sva.sv
// Checker for the stall cycle accounting block
`timescale 1ns/1ps
`default_nettype none
module sca_top_sva
    import sca_pkg::*;
(
    input wire logic                   MCLK,
    input wire logic                   RST,
    input wire sca_pkg::sca_backend_t  BACKEND,
    input wire sca_pkg::sca_frontend_t FRONTEND,
    input wire sca_pkg::sca_branch_t   BRANCH,
    input wire logic                   CYCLE_EVT,
    input wire logic                   DEP_ALL_EVT,
    input wire logic                   MEMORY_EVT,
    input wire logic                   CLEAN_BACKEND_EVT,
    input wire logic                   ALL_FLUSH_EVT,
    input wire logic                   DEP_SCOREBOARD_EVT,
    input wire logic                   DATA_ACCESS_EVT,
    input wire logic                   INST_ACCESS_EVT,
    input wire logic                   BACKEND_FLUSH_EVT,
    input wire sca_pkg::sca_brev_t     BRANCH_EVT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////
    a_one_category: assert property (CYCLE_EVT |-> $onehot({DEP_ALL_EVT,
        MEMORY_EVT, CLEAN_BACKEND_EVT, ALL_FLUSH_EVT})) else $error("category not one-hot");
    a_no_stray: assert property (!CYCLE_EVT |-> !(DEP_ALL_EVT || MEMORY_EVT ||
        CLEAN_BACKEND_EVT || ALL_FLUSH_EVT)) else $error("category without cycle");
    a_cycle_run: assert property (!RST |=> CYCLE_EVT) else $error("cycle pulse missing");
    a_sb_subset: assert property (DEP_SCOREBOARD_EVT |-> DEP_ALL_EVT)
        else $error("scoreboard outside dependency");
    a_data_subset: assert property (DATA_ACCESS_EVT |-> MEMORY_EVT)
        else $error("data access outside memory");
    a_inst_subset: assert property (INST_ACCESS_EVT |-> CLEAN_BACKEND_EVT)
        else $error("inst access outside clean");
    a_be_subset: assert property (BACKEND_FLUSH_EVT |-> ALL_FLUSH_EVT)
        else $error("backend flush outside flush");
    a_mem_wait: assert property (BACKEND.sb_stall_mem && BACKEND[5:0] == 6'h00 &&
        !FRONTEND.taken_resteer |=> MEMORY_EVT && DATA_ACCESS_EVT) else $error("memory wait lost");
    a_engine_only: assert property (BACKEND == 14'h0040 && !FRONTEND.taken_resteer
        |=> MEMORY_EVT && !DATA_ACCESS_EVT) else $error("engine stall misfiled");
    a_mispred_wins: assert property (BACKEND.br_mispredict_flush &&
        FRONTEND.taken_resteer |=> BACKEND_FLUSH_EVT) else $error("bubble beat mispredict");
    a_capture_pulse: assert property (BRANCH.valid && BRANCH.trace_capture
        |=> BRANCH_EVT.capture) else $error("capture pulse missing");
    a_inst_needs_empty: assert property (!FRONTEND.decouple_empty
        |=> !INST_ACCESS_EVT) else $error("inst access with busy buffer");
    a_multi_only: assert property (!(BRANCH.valid && BRANCH.multiway)
        |=> !BRANCH_EVT.multiway) else $error("multiway pulse on single-way bundle");
endmodule
bind sca_top sca_top_sva sca_top_sva_inst (.*);
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the stall cycle accounting block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sca_pkg::*;
    logic                MCLK;
    logic                RST;
    logic [3:0]          cause;
    logic [1:0]          miss;
    logic                rstr;
    logic                full;
    sca_backend_t        be;
    sca_frontend_t       fe;
    sca_branch_t         br;
    sca_umask_t          um;
    sca_brev_t           bev;
    wire logic [8:0]     obs;
    int                  err_total;
    int                  n_compared;
    int                  cyc;
    sca_pipe_model sca_pipe_model_inst (.cause(cause), .fe_miss(miss), .buf_full(full),
        .resteer(rstr), .be(be), .fe(fe));
    sca_top sca_top_inst (.MCLK(MCLK), .RST(RST), .BACKEND(be), .FRONTEND(fe), .BRANCH(br),
        .UMASK(um), .CYCLE_EVT(obs[8]), .DEP_ALL_EVT(obs[0]), .MEMORY_EVT(obs[1]),
        .CLEAN_BACKEND_EVT(obs[2]), .ALL_FLUSH_EVT(obs[3]), .DEP_SCOREBOARD_EVT(obs[4]),
        .DATA_ACCESS_EVT(obs[5]), .INST_ACCESS_EVT(obs[6]), .BACKEND_FLUSH_EVT(obs[7]),
        .BRANCH_EVT(bev));
    ////////////////////////////////////////////////////////////////////////
    // Clock and a hang guard far above the run's length
    always #2 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            results();
        end
    end
    task automatic results();
        if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One cycle of causes, judged one cycle later
    task automatic step(input logic [3:0] c, input logic [1:0] m, input logic r,
                        input logic [8:0] exp);
        @(posedge MCLK);
        cause <= c;
        miss <= m;
        rstr <= r;
        @(posedge MCLK);
        #1 check(obs, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_dependency();
        for (int i = 1; i < 5; i++) step(4'(i), 2'h0, 1'b0, i < 3 ? 9'h101 : 9'h111);
        step(4'h5, 2'h0, 1'b0, 9'h122);
    endtask
    task automatic t_memory();
        for (int i = 5; i < 9; i++) step(4'(i), 2'h0, 1'b0, i < 8 ? 9'h122 : 9'h102);
    endtask
    task automatic t_clean();
        for (int m = 0; m < 4; m++) step(4'h0, 2'(m), 1'b0, m > 0 ? 9'h144 : 9'h104);
        // Busy buffer hides the front-end miss
        @(posedge MCLK);
        miss <= 2'h3;
        full <= 1'b1;
        @(posedge MCLK);
        #1 check(obs, 9'h104);
        @(posedge MCLK);
        full <= 1'b0;
    endtask
    task automatic t_flush();
        for (int i = 9; i < 15; i++) step(4'(i), 2'h0, 1'b0, 9'h188);
        step(4'h0, 2'h3, 1'b1, 9'h108);
        step(4'h9, 2'h0, 1'b1, 9'h188);
    endtask
    // Branch classes: path, predictor, multiway, taken slot, capture
    task automatic t_branch();
        for (int o = 0; o < 5; o++) begin
            @(posedge MCLK);
            br <= '{1'b1, 1'b1, 1'b1, 1'b1, STAGE_SECOND, 1'b1, 1'b0, 2'h1, 1'b1};
            um <= '{1'b1, 1'b1, 1'b0, 1'b0, o < 4 ? STAGE_SECOND : STAGE_THIRD, 2'(o), 2'(o)};
            @(posedge MCLK);
            #1 check(9'(bev), o == 4 ? 9'h05 : {4'h0, 1'b1, o == 0 || o == 2,
                o == 0 || o == 2, o == 1, 1'b1});
        end
        // Single-way not-taken bundle, nothing captured
        @(posedge MCLK);
        br <= '{1'b1, 1'b0, 1'b0, 1'b0, STAGE_FIRST, 1'b0, 1'b0, 2'h0, 1'b0};
        um <= '0;
        @(posedge MCLK);
        #1 check(9'(bev), 9'h18);
        @(posedge MCLK);
        br <= '0;
        @(posedge MCLK);
        #1 check(9'(bev), 9'h00);
    endtask
    // Reset in mid-run silences every cycle and stall pulse
    task automatic t_reset();
        @(posedge MCLK);
        RST <= 1'b1;
        @(posedge MCLK);
        #1 check(obs, 9'h000);
        @(posedge MCLK);
        RST <= 1'b0;
        step(4'h0, 2'h0, 1'b0, 9'h104);
    endtask
    initial begin
        MCLK = 1'b0;
        RST = 1'b1;
        cause = 4'h0;
        miss = 2'h0;
        rstr = 1'b0;
        full = 1'b0;
        br = '0;
        um = '0;
        err_total = 0;
        n_compared = 0;
        cyc = 0;
        repeat (6) @(posedge MCLK);
        RST <= 1'b0;
        t_dependency();
        t_memory();
        t_clean();
        t_flush();
        t_branch();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
